// ---- shared/mag_pkg.sv ----
package mag_pkg;

    // ==========================================================
    // widths
    localparam int PTR_W  = 16;
    localparam int DATA_W = 16;
    localparam int ACC_W  = 40;
    localparam int REP_W  = 13;

    // ==========================================================
    // constants and reset values
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] PTR_STEP  = 16'h0002;
    localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
    localparam logic [39:0] ACC_ZERO  = 40'h00_0000_0000;
    localparam logic [39:0] SAT_POS   = 40'h00_7fff_ffff;
    localparam logic [39:0] SAT_NEG   = 40'hff_8000_0000;
    localparam logic [3:0]  SHIFT_MAX = 4'h8;
    localparam logic [12:0] REP_RESET = 13'h0000;
    localparam logic [12:0] REP_ONE   = 13'h0001;
    localparam logic [3:0]  FLAGS_RESET = 4'h0;

    // ==========================================================
    // status flag positions
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_OVF   = 1;
    localparam int FLAG_EXT   = 2;
    localparam int FLAG_LIMIT = 3;

    // ==========================================================
    // pointer and offset load selects
    localparam logic [2:0] PSEL_IDX_A = 3'h0;
    localparam logic [2:0] PSEL_IDX_B = 3'h1;
    localparam logic [2:0] PSEL_QR_A  = 3'h2;
    localparam logic [2:0] PSEL_QR_B  = 3'h3;
    localparam logic [2:0] PSEL_QX_A  = 3'h4;
    localparam logic [2:0] PSEL_QX_B  = 3'h5;

    // ==========================================================
    // types
    typedef enum logic [2:0] {MOD_NONE, MOD_INC, MOD_DEC, MOD_ADDQ, MOD_SUBQ} mag_mod_t;
    typedef enum logic [2:0] {OP_MUL, OP_MAC, OP_MACM, OP_MOV, OP_SHL, OP_SHR} mag_op_t;

    typedef struct packed {
        mag_op_t    op;
        logic       sgn;
        logic [3:0] gpr_num;
        mag_mod_t   gpr_mode;
        logic       gpr_q;
        logic       idx_sel;
        mag_mod_t   idx_mode;
        logic       idx_q;
        logic       direct;
        logic [3:0] shamt;
    } mag_instr_t;

endpackage

// ---- src/mag_addr_gen.sv ----
`timescale 1ns/1ns
module mag_addr_gen (
    // pointer in
    input  wire logic [15:0]        i_ptr,
    input  wire mag_pkg::mag_mod_t  i_mode,
    input  wire logic [15:0]        i_offset,
    // results
    output logic      [15:0]        o_next,
    output logic      [15:0]        o_reverse
);
    // 16-bit sums wrap inside the pointer width by construction
    always_comb begin
        unique case (i_mode)
            mag_pkg::MOD_NONE: begin
                o_next    = i_ptr;
                o_reverse = i_ptr;
            end
            mag_pkg::MOD_INC: begin
                o_next    = i_ptr + mag_pkg::PTR_STEP;
                o_reverse = o_next - mag_pkg::PTR_STEP;
            end
            mag_pkg::MOD_DEC: begin
                o_next    = i_ptr - mag_pkg::PTR_STEP;
                o_reverse = o_next + mag_pkg::PTR_STEP;
            end
            mag_pkg::MOD_ADDQ: begin
                o_next    = i_ptr + i_offset;
                o_reverse = o_next - i_offset;
            end
            mag_pkg::MOD_SUBQ: begin
                o_next    = i_ptr - i_offset;
                o_reverse = o_next + i_offset;
            end
            default: begin
                o_next    = i_ptr;
                o_reverse = i_ptr;
            end
        endcase
    end
endmodule // mag_addr_gen

// ---- src/mag_multiplier.sv ----
`timescale 1ns/1ns
module mag_multiplier (
    // operands
    input  wire logic [15:0] i_a,
    input  wire logic [15:0] i_b,
    input  wire logic        i_signed,
    // scaler control
    input  wire logic        i_scale,
    // result
    output logic      [39:0] o_product
);
    logic signed [16:0] a_ext;
    logic signed [16:0] b_ext;
    logic signed [33:0] full;
    logic        [31:0] prod;
    logic        [39:0] prod_ext;

    // one extra bit lets one signed multiplier serve both modes
    assign a_ext    = {i_signed & i_a[15], i_a};
    assign b_ext    = {i_signed & i_b[15], i_b};
    assign full     = a_ext * b_ext;
    assign prod     = full[31:0];
    assign prod_ext = {{8{i_signed & prod[31]}}, prod};
    // drop the duplicated sign bit of signed fractional products
    assign o_product = i_scale ? {prod_ext[38:0], 1'b0} : prod_ext;
endmodule // mag_multiplier

// ---- src/mag_mac_unit.sv ----
`timescale 1ns/1ns
// Operation
// - gpr pointer plus one index pointer
// - two offsets per pointer kind
// - index pointer post-modified five ways
// - any gpr post-modified five ways
// - index pointers internal only except move
// - parallel move only for mac-with-move
// - move address reverses index post-modification
// - four pipeline stages, double-word fetch
// - decode computes addresses, post-modifies pointers
// - execute updates accumulator, flags, gpr
// - write-back stage stores moved operand
// - immediate shift amount, direct gpr operands
// - 16x16 signed/unsigned multiply to 32 bits
// - optional one-bit product left scale
// - every mac operation executes in one cycle
// - 40-bit accumulator, saturation, 8-bit shifter
// - repeat up to 8192, interruptible
// - trap request on enabled flags set
// - count n gives n+1 executions
// - saturate to 32-bit extreme values
module mag_mac_unit (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    // instruction issue
    input  wire logic                 i_issue,
    input  wire mag_pkg::mag_op_t     i_op,
    input  wire logic                 i_signed,
    input  wire logic                 i_direct,
    input  wire logic [3:0]           i_shamt,
    input  wire logic                 i_repeat,
    input  wire logic [12:0]          i_rep_count,
    input  wire logic                 i_interrupt,
    // pointer addressing
    input  wire logic [3:0]           i_gpr_num,
    input  wire logic [15:0]          i_gpr_ptr,
    input  wire mag_pkg::mag_mod_t    i_gpr_mode,
    input  wire logic                 i_gpr_q_sel,
    input  wire logic                 i_idx_sel,
    input  wire mag_pkg::mag_mod_t    i_idx_mode,
    input  wire logic                 i_idx_q_sel,
    // pointer and offset loads
    input  wire logic                 i_ptr_wr,
    input  wire logic [2:0]           i_ptr_wr_sel,
    input  wire logic [15:0]          i_ptr_wr_data,
    // control
    input  wire logic                 i_product_scale_bit,
    input  wire logic                 i_sat_enable,
    input  wire logic                 i_trap_enable,
    input  wire logic [3:0]           i_trap_mask,
    input  wire logic [3:0]           i_flag_clr,
    // operand buses
    input  wire logic [15:0]          i_operand_bus_first,
    input  wire logic [15:0]          i_operand_bus_second,
    // issue status
    output logic                      o_ready,
    output logic                      o_repeat_flag,
    // operand reads
    output logic                      o_rd_req,
    output logic      [15:0]          o_rd_addr_first,
    output logic      [15:0]          o_rd_addr_second,
    output logic                      o_second_internal,
    // gpr pointer write-back
    output logic                      o_gpr_wr,
    output logic      [3:0]           o_gpr_wr_num,
    output logic      [15:0]          o_gpr_wr_data,
    // parallel move write-back
    output logic                      o_wb_req,
    output logic      [15:0]          o_wb_addr,
    output logic      [15:0]          o_wb_data,
    // accumulator and status
    output logic      [39:0]          o_acc,
    output logic      [3:0]           o_flags,
    output logic                      o_trap_req
);

    // ==========================================================
    // pointer and offset registers
    logic [15:0] index_pointer_a;
    logic [15:0] index_pointer_b;
    logic [15:0] reg_ptr_offset_a;
    logic [15:0] reg_ptr_offset_b;
    logic [15:0] index_offset_a;
    logic [15:0] index_offset_b;

    // ==========================================================
    // issue source selection
    mag_pkg::mag_instr_t in_instr;
    mag_pkg::mag_instr_t cur;
    mag_pkg::mag_instr_t src;
    mag_pkg::mag_mod_t   gpr_mode_eff;
    mag_pkg::mag_mod_t   idx_mode_eff;
    logic                fresh;
    logic                take;
    logic [15:0]         cur_gpr_ptr;
    logic [15:0]         src_gpr_ptr;
    logic [15:0]         idx_ptr;
    logic [15:0]         idx_off;
    logic [15:0]         gpr_off;
    logic [15:0]         gpr_next;
    logic [15:0]         idx_next;
    logic [15:0]         idx_rev;
    logic [12:0]         rep_cnt;

    assign in_instr = '{op: i_op, sgn: i_signed, gpr_num: i_gpr_num, gpr_mode: i_gpr_mode,
                        gpr_q: i_gpr_q_sel, idx_sel: i_idx_sel, idx_mode: i_idx_mode,
                        idx_q: i_idx_q_sel, direct: i_direct, shamt: i_shamt};
    assign fresh = i_issue && o_ready;
    // a paused repeat simply stops re-issuing; its count stays put
    assign take        = fresh || (o_repeat_flag && !i_interrupt);
    assign src         = fresh ? in_instr : cur;
    assign src_gpr_ptr = fresh ? i_gpr_ptr : cur_gpr_ptr;
    assign idx_ptr     = src.idx_sel ? index_pointer_b : index_pointer_a;
    assign idx_off     = src.idx_q ? index_offset_b : index_offset_a;
    assign gpr_off     = src.gpr_q ? reg_ptr_offset_b : reg_ptr_offset_a;
    // direct gpr operands carry no pointer at all
    assign gpr_mode_eff = src.direct ? mag_pkg::MOD_NONE : src.gpr_mode;
    assign idx_mode_eff = src.direct ? mag_pkg::MOD_NONE : src.idx_mode;

    // two generators so both pointers move in the same decode cycle
    mag_addr_gen u_gpr_gen (
        .i_ptr     (src_gpr_ptr),
        .i_mode    (gpr_mode_eff),
        .i_offset  (gpr_off),
        .o_next    (gpr_next),
        .o_reverse ()
    );

    mag_addr_gen u_idx_gen (
        .i_ptr     (idx_ptr),
        .i_mode    (idx_mode_eff),
        .i_offset  (idx_off),
        .o_next    (idx_next),
        .o_reverse (idx_rev)
    );

    // ==========================================================
    // pointer and offset storage
    // a core load in the same cycle as a post-modification wins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            index_pointer_a  <= mag_pkg::PTR_RESET;
            index_pointer_b  <= mag_pkg::PTR_RESET;
            reg_ptr_offset_a <= mag_pkg::PTR_RESET;
            reg_ptr_offset_b <= mag_pkg::PTR_RESET;
            index_offset_a   <= mag_pkg::PTR_RESET;
            index_offset_b   <= mag_pkg::PTR_RESET;
        end else begin
            if (take && !src.direct && !src.idx_sel) begin
                index_pointer_a <= idx_next;
            end
            if (take && !src.direct && src.idx_sel) begin
                index_pointer_b <= idx_next;
            end
            if (i_ptr_wr) begin
                unique case (i_ptr_wr_sel)
                    mag_pkg::PSEL_IDX_A: index_pointer_a  <= i_ptr_wr_data;
                    mag_pkg::PSEL_IDX_B: index_pointer_b  <= i_ptr_wr_data;
                    mag_pkg::PSEL_QR_A:  reg_ptr_offset_a <= i_ptr_wr_data;
                    mag_pkg::PSEL_QR_B:  reg_ptr_offset_b <= i_ptr_wr_data;
                    mag_pkg::PSEL_QX_A:  index_offset_a   <= i_ptr_wr_data;
                    mag_pkg::PSEL_QX_B:  index_offset_b   <= i_ptr_wr_data;
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // repeat unit
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_repeat_flag <= 1'b0;
            o_ready       <= 1'b1;
            rep_cnt       <= mag_pkg::REP_RESET;
        end else if (fresh) begin
            // count n: first issue plus n re-issues
            o_repeat_flag <= i_repeat && (i_rep_count != mag_pkg::REP_RESET);
            o_ready       <= !(i_repeat && (i_rep_count != mag_pkg::REP_RESET));
            rep_cnt       <= i_repeat ? i_rep_count : mag_pkg::REP_RESET;
        end else if (o_repeat_flag && !i_interrupt) begin
            o_repeat_flag <= rep_cnt != mag_pkg::REP_ONE;
            o_ready       <= rep_cnt == mag_pkg::REP_ONE;
            rep_cnt       <= rep_cnt - mag_pkg::REP_ONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cur         <= '0;
            cur_gpr_ptr <= mag_pkg::PTR_RESET;
        end else begin
            if (fresh) begin
                cur <= in_instr;
            end
            // repeats keep walking the gpr pointer locally
            if (take) begin
                cur_gpr_ptr <= gpr_next;
            end
        end
    end

    // ==========================================================
    // decode stage
    mag_pkg::mag_instr_t d_instr;
    logic                d_valid;
    logic [15:0]         d_gpr_new;
    logic [15:0]         d_wb_addr;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            d_valid           <= 1'b0;
            d_instr           <= '0;
            d_gpr_new         <= mag_pkg::PTR_RESET;
            d_wb_addr         <= mag_pkg::PTR_RESET;
            o_rd_req          <= 1'b0;
            o_rd_addr_first   <= mag_pkg::PTR_RESET;
            o_rd_addr_second  <= mag_pkg::PTR_RESET;
            o_second_internal <= 1'b1;
        end else begin
            d_valid  <= take;
            o_rd_req <= take && !src.direct;
            if (take) begin
                d_instr           <= src;
                d_gpr_new         <= gpr_next;
                d_wb_addr         <= idx_rev;
                o_rd_addr_first   <= src_gpr_ptr;
                o_rd_addr_second  <= idx_ptr;
                o_second_internal <= src.op != mag_pkg::OP_MOV;
            end
        end
    end

    // ==========================================================
    // execute stage
    mag_pkg::mag_instr_t e_instr;
    logic                e_valid;
    logic [15:0]         e_a;
    logic [15:0]         e_b;
    logic [15:0]         e_wb_addr;
    logic                e_move;
    logic                e_is_macm;
    logic [39:0]         product;

    assign e_is_macm = e_instr.op == mag_pkg::OP_MACM;
    assign e_move    = e_valid && e_is_macm && !e_instr.direct;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            e_valid       <= 1'b0;
            e_instr       <= '0;
            e_a           <= mag_pkg::PTR_RESET;
            e_b           <= mag_pkg::PTR_RESET;
            e_wb_addr     <= mag_pkg::PTR_RESET;
            o_gpr_wr      <= 1'b0;
            o_gpr_wr_num  <= 4'h0;
            o_gpr_wr_data <= mag_pkg::PTR_RESET;
        end else begin
            e_valid  <= d_valid;
            o_gpr_wr <= d_valid && !d_instr.direct && (d_instr.gpr_mode != mag_pkg::MOD_NONE);
            if (d_valid) begin
                e_instr       <= d_instr;
                e_a           <= i_operand_bus_first;
                e_b           <= i_operand_bus_second;
                e_wb_addr     <= d_wb_addr;
                o_gpr_wr_num  <= d_instr.gpr_num;
                o_gpr_wr_data <= d_gpr_new;
            end
        end
    end

    mag_multiplier u_mult (
        .i_a       (e_a),
        .i_b       (e_b),
        .i_signed  (e_instr.sgn),
        .i_scale   (i_product_scale_bit),
        .o_product (product)
    );

    // ==========================================================
    // arithmetic unit and shifter
    function automatic logic ovf32(input logic [39:0] v);
        return !((&v[39:31]) || !(|v[39:31]));
    endfunction

    logic [39:0] next_acc;
    logic [39:0] addend;
    logic [40:0] sum;
    logic [47:0] shl_ext;
    logic [3:0]  amt;
    logic [3:0]  flag_set;

    always_comb begin
        next_acc = o_acc;
        addend   = mag_pkg::ACC_ZERO;
        sum      = 41'h0;
        shl_ext  = 48'h0;
        flag_set = mag_pkg::FLAGS_RESET;
        amt      = (e_instr.shamt > mag_pkg::SHIFT_MAX) ? mag_pkg::SHIFT_MAX : e_instr.shamt;
        if (e_valid) begin
            unique case (e_instr.op)
                mag_pkg::OP_MUL, mag_pkg::OP_MAC, mag_pkg::OP_MACM: begin
                    addend   = (e_instr.op == mag_pkg::OP_MUL) ? mag_pkg::ACC_ZERO : o_acc;
                    sum      = {1'b0, product} + {1'b0, addend};
                    next_acc = sum[39:0];
                    flag_set[mag_pkg::FLAG_CARRY] = sum[40];
                    flag_set[mag_pkg::FLAG_OVF]   = (product[39] == addend[39]) && (sum[39] != product[39]);
                end
                mag_pkg::OP_SHL: begin
                    shl_ext  = {{8{o_acc[39]}}, o_acc} << amt;
                    next_acc = shl_ext[39:0];
                    flag_set[mag_pkg::FLAG_CARRY] = (amt != 4'h0) && shl_ext[40];
                    flag_set[mag_pkg::FLAG_OVF]   = !((&shl_ext[47:39]) || !(|shl_ext[47:39]));
                end
                mag_pkg::OP_SHR: begin
                    next_acc = $signed(o_acc) >>> amt;
                end
                mag_pkg::OP_MOV: begin
                    next_acc = o_acc;
                end
                default: begin
                    next_acc = o_acc;
                end
            endcase
            if (i_sat_enable && ovf32(next_acc) && (e_instr.op != mag_pkg::OP_SHR)
                && (e_instr.op != mag_pkg::OP_MOV)) begin
                next_acc = next_acc[39] ? mag_pkg::SAT_NEG : mag_pkg::SAT_POS;
                flag_set[mag_pkg::FLAG_LIMIT] = 1'b1;
            end
            flag_set[mag_pkg::FLAG_EXT] = ovf32(next_acc);
        end
    end

    // ==========================================================
    // accumulator, flags, trap and move write-back
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_acc      <= mag_pkg::ACC_RESET;
            o_flags    <= mag_pkg::FLAGS_RESET;
            o_trap_req <= 1'b0;
            o_wb_req   <= 1'b0;
            o_wb_addr  <= mag_pkg::PTR_RESET;
            o_wb_data  <= mag_pkg::PTR_RESET;
        end else begin
            o_acc   <= next_acc;
            // a flag raised in its clear cycle stays set
            o_flags <= (o_flags & ~i_flag_clr) | flag_set;
            o_trap_req <= i_trap_enable
                          && (|(flag_set & ~(o_flags & ~i_flag_clr) & i_trap_mask));
            o_wb_req <= e_move;
            if (e_move) begin
                o_wb_addr <= e_wb_addr;
                o_wb_data <= e_b;
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_exec_done;
        d_valid ##1 e_valid;
    endsequence

    sequence s_move_out;
        e_valid ##1 o_wb_req;
    endsequence

    a_pipe_two_cycle: assert property (take |=> s_exec_done)
        else $error("instruction did not reach execute two cycles after issue");
    a_gpr_write_back: assert property (d_valid && !d_instr.direct && d_instr.gpr_mode != mag_pkg::MOD_NONE
        |=> o_gpr_wr && o_gpr_wr_data == $past(d_gpr_new))
        else $error("modified gpr pointer not written back in execute");
    a_move_write: assert property (take && src.op == mag_pkg::OP_MACM && !src.direct |=> ##1 s_move_out)
        else $error("parallel move not written in write-back stage");
    a_move_class: assert property (o_wb_req |-> $past(e_is_macm))
        else $error("parallel move from a non move instruction");
    a_move_reverse: assert property (o_wb_req |-> o_wb_addr == $past(o_rd_addr_second, 2))
        else $error("move address is not the reversed index pointer");
    a_idx_step_up: assert property (take && !src.direct && !src.idx_sel && src.idx_mode == mag_pkg::MOD_INC
        && !i_ptr_wr |=> index_pointer_a == $past(index_pointer_a) + mag_pkg::PTR_STEP)
        else $error("index pointer not advanced by two");
    a_sat_bound: assert property (e_valid && i_sat_enable
        && (e_instr.op == mag_pkg::OP_MUL || e_instr.op == mag_pkg::OP_MAC) |=> !ovf32(o_acc))
        else $error("saturated accumulator beyond 32 bits");
    a_trap_cause: assert property (o_trap_req |-> $past(i_trap_enable) && (|(o_flags & $past(i_trap_mask))))
        else $error("trap raised without an enabled flag");
    a_repeat_count: assert property (o_repeat_flag && !i_interrupt |=> rep_cnt == $past(rep_cnt) - mag_pkg::REP_ONE)
        else $error("repeat count not decremented");
    a_idx_internal: assert property (o_rd_req && !o_second_internal |-> d_instr.op == mag_pkg::OP_MOV)
        else $error("index pointer left internal ram outside move");

endmodule // mag_mac_unit

// ---- dv/mag_core_model.sv ----
`timescale 1ns/1ns
// ==========================================================
// core operand supply: each ram word reads as its address plus 1 on the first bus and plus 3 on the second
module mag_core_model (
    // read request from the decode stage
    input  wire logic        i_clk,
    input  wire logic        i_rd_req,
    input  wire logic [15:0] i_addr_first,
    input  wire logic [15:0] i_addr_second,
    // operand buses
    output logic      [15:0] o_first,
    output logic      [15:0] o_second
);
    logic [15:0] last_first = 16'h0000;
    logic [15:0] last_second = 16'h0000;
    always_ff @(posedge i_clk) begin
        last_first  <= o_first;
        last_second <= o_second;
    end
    // buses float outside a read, so show a changing pattern rather than stale data
    assign o_first  = i_rd_req ? i_addr_first + 16'h0001 : ~last_first;
    assign o_second = i_rd_req ? i_addr_second + 16'h0003 : ~last_second;
endmodule // mag_core_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    // ==========================================================
    // signals
    logic        clk = '0, rst = '1, issue = '0, sg = '0, sc = '0, rep = '0, intr = '0, pwr = '0, q = '0;
    logic        rd, rflag, si, gw, wr, rdy, trap;
    logic        dir = '0, sat = '0;
    logic [2:0]  psel = 3'h0;
    logic [12:0] rcnt = 13'h0000;
    logic [15:0] gp = 16'h0000, pd = 16'h0000, ba, bb, ra, rb, gd, wa, wd;
    logic [3:0]  gn, flags, sh = 4'h0, clr = 4'h0;
    logic [39:0] acc;
    int          bad_count = 0, compares = 0;
    mag_pkg::mag_op_t  op = mag_pkg::OP_MAC;
    mag_pkg::mag_mod_t gm = mag_pkg::MOD_NONE, im = mag_pkg::MOD_NONE;
    always #10 clk = ~clk;
    mag_core_model core (.i_clk(clk), .i_rd_req(rd), .i_addr_first(ra), .i_addr_second(rb),
        .o_first(ba), .o_second(bb));
    mag_mac_unit dut (.i_clk(clk), .i_rst(rst), .i_issue(issue), .i_op(op), .i_signed(sg),
        .i_direct(dir), .i_shamt(sh), .i_repeat(rep), .i_rep_count(rcnt), .i_interrupt(intr),
        .i_gpr_num(gp[4:1]), .i_gpr_ptr(gp), .i_gpr_mode(gm), .i_gpr_q_sel(q), .i_idx_sel(q),
        .i_idx_mode(im), .i_idx_q_sel(q), .i_ptr_wr(pwr), .i_ptr_wr_sel(psel), .i_ptr_wr_data(pd),
        .i_product_scale_bit(sc), .i_sat_enable(sat), .i_trap_enable(sg), .i_trap_mask(4'hf),
        .i_flag_clr(clr), .i_operand_bus_first(ba), .i_operand_bus_second(bb), .o_ready(rdy),
        .o_repeat_flag(rflag), .o_rd_req(rd), .o_rd_addr_first(ra), .o_rd_addr_second(rb),
        .o_second_internal(si), .o_gpr_wr(gw), .o_gpr_wr_num(gn), .o_gpr_wr_data(gd), .o_wb_req(wr),
        .o_wb_addr(wa), .o_wb_data(wd), .o_acc(acc), .o_flags(flags), .o_trap_req(trap));
    // ==========================================================
    // shared tasks
    task automatic cmp(string n, logic [39:0] g, logic [39:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic nxt;
        @(posedge clk);
        #1;
    endtask
    // returns just after the edge that takes the issue
    task automatic go(mag_pkg::mag_op_t o, logic s, logic c, logic [15:0] g, mag_pkg::mag_mod_t m, x);
        @(posedge clk);
        op <= o;
        sg <= s;
        sc <= c;
        gp <= g;
        gm <= m;
        im <= x;
        issue <= 1'b1;
        @(posedge clk);
        issue <= 1'b0;
        #1;
    endtask
    task automatic conclude;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_move_mac;
        go(mag_pkg::OP_MACM, 1'b0, 1'b0, 16'h0200, mag_pkg::MOD_INC, mag_pkg::MOD_INC);
        cmp("decode", {rd, si, ra, rb}, {2'h3, 16'h0200, 16'h0100});
        nxt();
        cmp("gpr_wb", {gw, gn, gd}, {1'b1, 4'h0, 16'h0202});
        nxt();
        cmp("acc", acc, 40'h00_0002_0703);
        cmp("move", {wr, wa, wd}, {1'b1, 16'h0100, 16'h0103});
    endtask
    task automatic t_signed_mul;
        go(mag_pkg::OP_MUL, 1'b1, 1'b1, 16'hfffe, mag_pkg::MOD_INC, mag_pkg::MOD_DEC);
        cmp("decode", {ra, rb}, {16'hfffe, 16'h0102});
        nxt();
        cmp("gpr_wb", {gw, gn, gd}, {1'b1, 4'hf, 16'h0000});
        nxt();
        cmp("product", {wr, acc}, {1'b0, 40'hff_ffff_fdf6});
    endtask
    task automatic t_repeat;
        int n;
        @(posedge clk);
        rep <= 1'b1;
        rcnt <= 13'h0002;
        go(mag_pkg::OP_MAC, 1'b0, 1'b0, 16'h0400, mag_pkg::MOD_NONE, mag_pkg::MOD_NONE);
        n = 0;
        for (int i = 0; i < 8; i++) begin
            n += int'(rd);
            if (i == 2)
                cmp("paused", {rdy, rflag, rd}, 3'h2);
            @(posedge clk);
            rep <= 1'b0;
            intr <= (i == 0);
            #1;
        end
        cmp("runs", 40'(n), 40'h3);
        cmp("done", {rdy, rflag}, 2'h2);
    endtask
    // 8000h squared and scaled overflows 32 bits, so saturation and the trap fire together
    task automatic t_saturate;
        @(posedge clk);
        pwr <= 1'b1;
        psel <= mag_pkg::PSEL_IDX_A;
        pd <= 16'h7ffd;
        clr <= 4'hf;
        sat <= 1'b1;
        @(posedge clk);
        pwr <= 1'b0;
        clr <= 4'h0;
        go(mag_pkg::OP_MUL, 1'b1, 1'b1, 16'h7fff, mag_pkg::MOD_NONE, mag_pkg::MOD_NONE);
        nxt();
        nxt();
        cmp("saturate", acc, 40'h00_7fff_ffff);
        cmp("flags_trap", {trap, flags}, {1'b1, 4'h8});
        nxt();
        cmp("trap_pulse", {trap, flags}, {1'b0, 4'h8});
    endtask
    task automatic t_shift;
        @(posedge clk);
        dir <= 1'b1;
        sat <= 1'b0;
        sh <= 4'h4;
        go(mag_pkg::OP_SHR, 1'b0, 1'b0, 16'h0500, mag_pkg::MOD_INC, mag_pkg::MOD_INC);
        cmp("direct_rd", rd, 1'b0);
        nxt();
        cmp("direct_gpr", gw, 1'b0);
        sh <= 4'h9;
        go(mag_pkg::OP_SHL, 1'b0, 1'b0, 16'h0500, mag_pkg::MOD_INC, mag_pkg::MOD_INC);
        cmp("shr", acc, 40'h00_07ff_ffff);
        nxt();
        nxt();
        cmp("shl_clamp", acc, 40'h07_ffff_ff00);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pwr <= 1'b1;
        psel <= mag_pkg::PSEL_IDX_A;
        pd <= 16'h0100;
        @(posedge clk);
        pwr <= 1'b0;
        t_move_mac();
        t_signed_mul();
        go(mag_pkg::OP_MOV, 1'b0, 1'b0, 16'h0300, mag_pkg::MOD_NONE, mag_pkg::MOD_INC);
        cmp("mov_space", {rd, si}, 2'h2);
        t_repeat();
        t_saturate();
        t_shift();
        conclude();
    end
    initial begin
        repeat (400) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule // testbench
